// ---- ptl_defs.vh ----
// How it works
// [RULE1] Software gate: count up each timer clock while run is set, else hold.
// [RULE2] On period match the counter returns to zero next clock and keeps counting.
// [RULE3] Hardware gate: like software gate; mode 00001 counts while external level is high.
// [RULE4] Mode 00010 counts only while run is set and the external level is low.
// [RULE5] Edge limit modes reset early: any edge 00011, rising 00100, falling 00101.
// [RULE6] After an early edge reset the start indication follows two timer clocks later.
// [RULE7] Level limit modes hold the counter reset: low level 00110, high level 00111.
// [RULE8] In level limit modes the external level is ignored while run is clear.
// [RULE9] Level limit resets on match or two clocks after the active level persists.
// [RULE10] Counting and period start resume after match or two clocks after release.
// [RULE11] Software one-shot: period match resets the counter and clears run.
// [RULE12] Software must set run again to begin each new one-shot cycle.
// [RULE13] Software one-shot: clearing then setting run pauses and resumes the count.
// [RULE14] One-shot modes: clock after match clears run and leaves counter at zero.
// [RULE15] Edge one-shot starts on edge after run set: 01001 rise, 01010 fall, 01011 any.
// [RULE16] A halted edge one-shot needs a fresh qualifying edge after run is set.
// [RULE17] With the alternate clock, run and external pass two timer-clock sync stages.
// [RULE18] With the instruction clock, run applies next cycle, external after the two pin sync stages.
// [RULE19] Counter advances on the prescaled clock; match events pass a postscaler.
`ifndef PTL_DEFS_VH
`define PTL_DEFS_VH

`define PTL_ADDR_CTRL    3'h0
`define PTL_ADDR_PERIOD  3'h1
`define PTL_ADDR_COUNT   3'h2
`define PTL_ADDR_SCALE   3'h3
`define PTL_ADDR_COMPARE 3'h4
`define PTL_ADDR_STATUS  3'h5

`define PTL_CTRL_RUN_BIT 7
`define PTL_CTRL_CLK_BIT 6
`define PTL_CTRL_MODE_HI 4
`define PTL_SCALE_PRE_HI 2
`define PTL_SCALE_POST_LO 4
`define PTL_SCALE_POST_HI 7

`define PTL_RST_MODE     5'h00
`define PTL_RST_PERIOD   8'hff
`define PTL_RST_COMPARE  8'h00

`define PTL_MODE_SWGATE  5'h00
`define PTL_MODE_GATE_HI 5'h01
`define PTL_MODE_GATE_LO 5'h02
`define PTL_MODE_LIM_ANY 5'h03
`define PTL_MODE_LIM_RIS 5'h04
`define PTL_MODE_LIM_FAL 5'h05
`define PTL_MODE_LVL_LO  5'h06
`define PTL_MODE_LVL_HI  5'h07
`define PTL_MODE_OS_SW   5'h08
`define PTL_MODE_OS_RIS  5'h09
`define PTL_MODE_OS_FAL  5'h0a
`define PTL_MODE_OS_ANY  5'h0b

`define PTL_LVL_DLY      2'h2
`define PTL_EDGE_DLY     2

`endif

// ---- ptl_properties.sv ----
`timescale 1ns/1ps
`include "ptl_defs.vh"
module ptl_properties (
  input wire       mclk_in,
  input wire       sys_rst_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       ext_reset_source_in,
  input wire [7:0] count_value_out,
  input wire       pwm_start_out,
  input wire       period_match_out,
  input wire       run_out
);
  reg  [7:0] ctl;
  reg  [2:0] pre;
  wire [4:0] md = ctl[4:0];
  // Exact cycle figures only hold with the fast clock and no prescale
  wire       fast = !ctl[6] && pre == 3'h0;
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctl <= 8'h00;
      pre <= 3'h0;
    end else if (wr_in && addr_in == `PTL_ADDR_CTRL) begin
      ctl <= wdata_in;
    end else if (wr_in && addr_in == `PTL_ADDR_SCALE) begin
      pre <= wdata_in[2:0];
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  sequence edge_hit;
    fast && run_out && $past(run_out, 4) && (md == `PTL_MODE_LIM_RIS && $rose(ext_reset_source_in)
      || md == `PTL_MODE_LIM_FAL && $fell(ext_reset_source_in)
      || md == `PTL_MODE_LIM_ANY && $changed(ext_reset_source_in));
  endsequence
  chk_count_step: assert property (!$past(wr_in && addr_in == `PTL_ADDR_COUNT) && $changed(count_value_out)
    |-> count_value_out == $past(count_value_out) + 8'h01 || count_value_out == 8'h00) else $error("count jumped");
  chk_match_zero: assert property (period_match_out |-> count_value_out <= 8'h01)
    else $error("match without wrap");
  chk_oneshot_stop: assert property ($fell(run_out) && md >= `PTL_MODE_OS_SW && md <= `PTL_MODE_OS_ANY
    && !$past(wr_in && addr_in == `PTL_ADDR_CTRL) |-> count_value_out == 8'h00) else $error("one-shot not at zero");
  chk_stop_holds: assert property ((!run_out && !wr_in && !(md >= `PTL_MODE_LIM_ANY && md <= `PTL_MODE_LIM_FAL))[*3]
    |-> $stable(count_value_out)) else $error("count moved while stopped");
  chk_level_hold: assert property ((md == `PTL_MODE_LVL_HI && fast && run_out && ext_reset_source_in && !wr_in)[*8]
    |-> count_value_out == 8'h00) else $error("level reset not held");
  chk_level_release: assert property ((md == `PTL_MODE_LVL_HI && fast && run_out && ext_reset_source_in)[*8]
    ##1 !ext_reset_source_in |-> ##[1:8] pwm_start_out) else $error("no restart after release");
  chk_edge_zero: assert property (edge_hit |-> ##[1:6] count_value_out == 8'h00) else $error("edge did not reset");
  chk_edge_start: assert property (edge_hit |-> ##[2:8] pwm_start_out) else $error("no start after edge");
  cover property (period_match_out);
  cover property ($fell(run_out) && md == `PTL_MODE_OS_SW);
  cover property (pwm_start_out && md == `PTL_MODE_LIM_RIS);
endmodule
bind ptl_timer ptl_properties u_ptl_properties (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .ext_reset_source_in(ext_reset_source_in), .count_value_out(count_value_out), .pwm_start_out(pwm_start_out),
  .period_match_out(period_match_out), .run_out(run_out)
);

// ---- ptl_pwm_unit.sv ----
`timescale 1ns/1ps
module ptl_pwm_unit (
  input  wire       mclk_in,
  input  wire       sys_rst_in,
  input  wire       level_cmd_in,
  input  wire       pwm_start_in,
  input  wire [7:0] count_value_in,
  input  wire [7:0] pulse_width_compare_in,
  output reg        ext_reset_source_out = 1'b0,
  output reg        pwm_out,
  output reg  [7:0] n_starts_out
);
  always @(posedge mclk_in) begin
    ext_reset_source_out <= level_cmd_in;
    if (sys_rst_in) begin
      pwm_out <= 1'b0;
      n_starts_out <= 8'h00;
    end else if (pwm_start_in) begin
      pwm_out <= 1'b1;
      n_starts_out <= n_starts_out + 8'h01;
    end else if (count_value_in == pulse_width_compare_in) begin
      // Start wins over compare, so a very short period still shows a pulse
      pwm_out <= 1'b0;
    end
  end
endmodule

// ---- ptl_scaler.v ----
`timescale 1ns/1ps
module ptl_scaler (
  input  wire       mclk_in,
  input  wire       sys_rst_in,
  input  wire       ce_in,
  input  wire [7:0] limit_in,
  input  wire       pulse_in,
  output wire       pulse_out
);
  reg [7:0] cnt;

  // Greater-or-equal so a lowered ratio cannot strand the count
  assign pulse_out = pulse_in && (cnt >= limit_in);

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cnt <= 8'h00;
    end else if (ce_in && pulse_in) begin
      if (cnt >= limit_in) begin
        cnt <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule

// ---- ptl_sync.v ----
`timescale 1ns/1ps
module ptl_sync #(
  parameter W = 1
) (
  input  wire         mclk_in,
  input  wire         sys_rst_in,
  input  wire         ce_in,
  input  wire         en_in,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);
  reg [W-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      meta  <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else if (ce_in && en_in) begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ---- ptl_timer.v ----
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ptl_defs.vh"
module ptl_timer (
  input  wire       mclk_in,
  input  wire       sys_rst_in,
  input  wire       ce_in,
  input  wire [2:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  input  wire       ext_reset_source_in,
  input  wire       alt_clk_in,
  output reg  [7:0] count_value_out,
  output reg  [7:0] pulse_width_compare_out,
  output reg        pwm_start_out,
  output reg        period_match_out,
  output reg        postscale_event_out,
  output reg        run_out
);

  reg  [4:0] mode;
  reg        clk_sel;
  reg  [7:0] period_value;
  reg  [2:0] prescale_select;
  reg  [3:0] postscale_select;
  reg        alt_prev;
  reg        ext_prev;
  reg        armed;
  reg        hold;
  reg  [1:0] act_cnt;
  reg  [1:0] rel_cnt;
  reg  [`PTL_EDGE_DLY-1:0] early_dly;

  reg  [7:0] next_count;
  reg        next_armed;
  reg        next_hold;
  reg  [1:0] next_act;
  reg  [1:0] next_rel;
  reg        hw_clear;
  reg        restart;
  reg        early;
  reg        match_wrap;

  wire       alt_p;
  wire       ext_p;
  wire       run_t;
  wire       ext_t;
  wire       src_tick;
  wire       tick;
  wire       post_pulse;
  wire       run_s;
  wire       ext_s;
  wire       go;
  wire       match;
  wire       rise;
  wire       fall;
  wire       wr_ctrl;
  wire       wr_count;
  wire       wr_period;
  wire       wr_scale;
  wire       wr_compare;

  function [7:0] pow2m1;
    input [2:0] sel;
    begin
      pow2m1 = (8'h01 << sel) - 8'h01;
    end
  endfunction

  function edge_hit;
    input r;
    input f;
    input want_r;
    input want_f;
    begin
      edge_hit = (r && want_r) || (f && want_f);
    end
  endfunction

  // Pins cross into the clock domain before anything looks at them
  ptl_sync #(
    .W (2)
  ) u_pin_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .en_in      (1'b1),
    .d_in       ({alt_clk_in, ext_reset_source_in}),
    .q_out      ({alt_p, ext_p})
  );

  assign src_tick = clk_sel ? (alt_p && !alt_prev) : 1'b1;

  ptl_scaler u_prescale (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .limit_in   (pow2m1(prescale_select)),
    .pulse_in   (src_tick),
    .pulse_out  (tick)
  ); // RULE19

  // Two further stages clocked by the timer tick on the alternate clock
  ptl_sync #(
    .W (2)
  ) u_tick_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .en_in      (tick),
    .d_in       ({run_out, ext_p}),
    .q_out      ({run_t, ext_t})
  ); // RULE17

  assign run_s = clk_sel ? run_t : run_out; // RULE17 RULE18
  assign ext_s = clk_sel ? ext_t : ext_p; // RULE18

  // Raw run bit also gates so a hardware clear stops at once
  assign go    = run_s && run_out;
  // Live compare: a period written below the count lets it run on to the wrap
  assign match = (count_value_out == period_value);
  assign rise  = ext_s && !ext_prev;
  assign fall  = !ext_s && ext_prev;

  assign wr_ctrl  = wr_in && (addr_in == `PTL_ADDR_CTRL);
  assign wr_count = wr_in && (addr_in == `PTL_ADDR_COUNT);
  // Status and the unmapped slots have no write decode, so writes there vanish
  assign wr_period  = wr_in && (addr_in == `PTL_ADDR_PERIOD);
  assign wr_scale   = wr_in && (addr_in == `PTL_ADDR_SCALE);
  assign wr_compare = wr_in && (addr_in == `PTL_ADDR_COMPARE);

  ptl_scaler u_postscale (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .limit_in   ({4'h0, postscale_select}),
    .pulse_in   (tick && match_wrap),
    .pulse_out  (post_pulse)
  ); // RULE19

  always @* begin
    next_count = count_value_out;
    next_armed = armed;
    next_hold  = hold;
    next_act   = act_cnt;
    next_rel   = rel_cnt;
    hw_clear   = 1'b0;
    restart    = 1'b0;
    early      = 1'b0;
    match_wrap = 1'b0;
    case (mode)
      `PTL_MODE_SWGATE: begin
        if (go) begin // RULE1
          if (match) begin
            next_count = 8'h00; // RULE2
            match_wrap = 1'b1;
          end else begin
            next_count = count_value_out + 8'h01;
          end
        end
      end
      `PTL_MODE_GATE_HI,
      `PTL_MODE_GATE_LO: begin
        if (go && (ext_s == !mode[1])) begin // RULE3 RULE4
          if (match) begin
            next_count = 8'h00;
            match_wrap = 1'b1;
          end else begin
            next_count = count_value_out + 8'h01;
          end
        end
      end
      `PTL_MODE_LIM_ANY,
      `PTL_MODE_LIM_RIS,
      `PTL_MODE_LIM_FAL: begin
        if (go) begin
          if (edge_hit(rise, fall, mode != `PTL_MODE_LIM_FAL, mode != `PTL_MODE_LIM_RIS)) begin
            next_count = 8'h00; // RULE5
            early      = 1'b1;
          end else if (match) begin
            next_count = 8'h00;
            match_wrap = 1'b1;
          end else begin
            next_count = count_value_out + 8'h01;
          end
        end
      end
      `PTL_MODE_LVL_LO,
      `PTL_MODE_LVL_HI: begin
        // Level ignored while run is clear
        if (go) begin // RULE8
          if (ext_s == mode[0]) begin // RULE7
            next_rel = 2'h0;
            if (hold || act_cnt == `PTL_LVL_DLY - 2'h1) begin
              next_hold  = 1'b1; // RULE9
              next_count = 8'h00;
            end else begin
              next_act = act_cnt + 2'h1;
              if (match) begin
                next_count = 8'h00;
                match_wrap = 1'b1;
              end else begin
                next_count = count_value_out + 8'h01;
              end
            end
          end else if (hold) begin
            next_act = 2'h0;
            if (rel_cnt == `PTL_LVL_DLY - 2'h1) begin
              next_hold = 1'b0; // RULE10
              next_rel  = 2'h0;
              restart   = 1'b1;
            end else begin
              next_rel = rel_cnt + 2'h1;
            end
          end else begin
            next_act = 2'h0;
            if (match) begin
              next_count = 8'h00;
              match_wrap = 1'b1; // RULE10
            end else begin
              next_count = count_value_out + 8'h01;
            end
          end
        end
      end
      `PTL_MODE_OS_SW: begin
        if (go) begin // RULE13
          if (match) begin
            next_count = 8'h00; // RULE11 RULE14
            hw_clear   = 1'b1;
            match_wrap = 1'b1;
          end else begin
            next_count = count_value_out + 8'h01;
          end
        end
      end
      `PTL_MODE_OS_RIS,
      `PTL_MODE_OS_FAL,
      `PTL_MODE_OS_ANY: begin
        if (go && !armed) begin
          if (edge_hit(rise, fall, mode[0], mode[1])) begin
            next_armed = 1'b1; // RULE15
            restart    = 1'b1;
          end
        end else if (go && armed) begin
          if (match) begin
            next_count = 8'h00; // RULE14 RULE15
            hw_clear   = 1'b1;
            next_armed = 1'b0;
            match_wrap = 1'b1;
          end else begin
            next_count = count_value_out + 8'h01;
          end
        end
      end
      default: begin
        next_count = count_value_out;
      end
    endcase
    // A halted edge one-shot must see a new edge
    if (!run_out) begin
      next_armed = 1'b0; // RULE16
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mode                    <= `PTL_RST_MODE;
      clk_sel                 <= 1'b0;
      run_out                 <= 1'b0;
      period_value            <= `PTL_RST_PERIOD;
      prescale_select         <= 3'h0;
      postscale_select        <= 4'h0;
      pulse_width_compare_out <= `PTL_RST_COMPARE;
      count_value_out         <= 8'h00;
      alt_prev                <= 1'b0;
      ext_prev                <= 1'b0;
      armed                   <= 1'b0;
      hold                    <= 1'b0;
      act_cnt                 <= 2'h0;
      rel_cnt                 <= 2'h0;
      early_dly               <= {`PTL_EDGE_DLY{1'b0}};
      pwm_start_out           <= 1'b0;
      period_match_out        <= 1'b0;
      postscale_event_out     <= 1'b0;
      rdata_out               <= 8'h00;
    end else if (ce_in) begin
      alt_prev            <= alt_p;
      pwm_start_out       <= tick && (restart || match_wrap || early_dly[`PTL_EDGE_DLY-1]); // RULE6 RULE10
      period_match_out    <= tick && match_wrap;
      postscale_event_out <= post_pulse; // RULE19
      // Event state steps only on ticks, so the prescaler stretches the edge and level delays but not the pin sync stages
      if (tick) begin
        ext_prev  <= ext_s;
        armed     <= next_armed;
        hold      <= next_hold;
        act_cnt   <= next_act;
        rel_cnt   <= next_rel;
        early_dly <= {early_dly[`PTL_EDGE_DLY-2:0], early}; // RULE6
      end
      // Software write beats the tick update in the same cycle
      if (wr_count) begin
        count_value_out <= wdata_in;
      end else if (tick) begin
        count_value_out <= next_count;
      end
      // Software setting run wins over a hardware clear
      if (wr_ctrl) begin
        run_out <= wdata_in[`PTL_CTRL_RUN_BIT]; // RULE12
        clk_sel <= wdata_in[`PTL_CTRL_CLK_BIT];
        mode    <= wdata_in[`PTL_CTRL_MODE_HI:0];
      end else if (tick && hw_clear) begin
        run_out <= 1'b0; // RULE11 RULE14
      end
      if (wr_period) begin
        period_value <= wdata_in;
      end
      if (wr_scale) begin
        prescale_select  <= wdata_in[`PTL_SCALE_PRE_HI:0];
        postscale_select <= wdata_in[`PTL_SCALE_POST_HI:`PTL_SCALE_POST_LO];
      end
      if (wr_compare) begin
        pulse_width_compare_out <= wdata_in;
      end
      // Read data lives for exactly one cycle
      if (rd_in) begin
        case (addr_in)
          `PTL_ADDR_CTRL:    rdata_out <= {run_out, clk_sel, 1'b0, mode};
          `PTL_ADDR_PERIOD:  rdata_out <= period_value;
          `PTL_ADDR_COUNT:   rdata_out <= count_value_out;
          `PTL_ADDR_SCALE:   rdata_out <= {postscale_select, 1'b0, prescale_select};
          `PTL_ADDR_COMPARE: rdata_out <= pulse_width_compare_out;
          `PTL_ADDR_STATUS:  rdata_out <= {4'h0, ext_s, run_s, hold, armed};
          default:           rdata_out <= 8'h00;
        endcase
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "ptl_defs.vh"
module tb_top;
  reg         mclk_in = 1'b0;
  reg         sys_rst_in = 1'b1;
  reg  [2:0]  addr_in = 3'h0;
  reg  [7:0]  wdata_in = 8'h00;
  reg         wr_in = 1'b0;
  reg         rd_in = 1'b0;
  reg         lvl = 1'b0;
  reg         alt = 1'b0;
  reg  [7:0]  v;
  reg  [23:0] rows [0:7];
  wire [7:0]  rdata_out;
  wire        ext;
  wire [7:0]  count_value_out;
  wire [7:0]  cmp;
  wire        pwm_start_out;
  wire        period_match_out;
  wire        postscale_event_out;
  wire        run_out;
  wire [7:0]  starts;
  integer     n_errors = 0;
  integer     checks = 0;
  integer     n_pm = 0;
  integer     n_pe = 0;
  integer     i, j, m, pm0, pe0;
  ptl_timer u_ptl_timer (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_reset_source_in(ext),
    .alt_clk_in(alt), .count_value_out(count_value_out), .pulse_width_compare_out(cmp),
    .pwm_start_out(pwm_start_out), .period_match_out(period_match_out),
    .postscale_event_out(postscale_event_out), .run_out(run_out));
  ptl_pwm_unit u_ptl_pwm_unit (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .level_cmd_in(lvl),
    .pwm_start_in(pwm_start_out), .count_value_in(count_value_out), .pulse_width_compare_in(cmp),
    .ext_reset_source_out(ext), .pwm_out(), .n_starts_out(starts));
  always #25 mclk_in = ~mclk_in;
  // Free-running alternate timer clock at half the main rate
  always @(posedge mclk_in) alt <= ~alt;
  always @(posedge mclk_in) begin
    n_pm <= n_pm + period_match_out;
    n_pe <= n_pe + postscale_event_out;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge mclk_in);
      #1;
    end
  endtask
  task setx(input b);
    begin
      @(posedge mclk_in);
      lvl <= b;
    end
  endtask
  task kick(input b);
    begin
      setx(!b);
      tick(3);
      setx(b);
      tick(3);
    end
  endtask
  task rst(input integer n);
    begin
      @(posedge mclk_in);
      sys_rst_in <= 1'b1;
      repeat (n) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Bounded wait: 0 waits for count five, 1 waits for run to clear
  task poll(input integer w);
    begin
      // Callers may return on the launching edge; let outputs settle first
      #1;
      j = 0;
      while ((w ? run_out !== 1'b0 : count_value_out !== 8'h05) && j < 100) begin
        tick(1);
        j = j + 1;
      end
      if (j >= 100) begin
        n_errors = n_errors + 1;
        conclude;
      end
    end
  endtask
  initial begin
    rows[0] = 24'h01a5a5; rows[1] = 24'h043c3c; rows[2] = 24'h030000; rows[3] = 24'h000b0b;
    rows[4] = 24'h06ff00; rows[5] = 24'h075a00; rows[6] = 24'h023333; rows[7] = 24'h05ff00;
    rst(10);
    rd(`PTL_ADDR_PERIOD, v);
    chk(v, `PTL_RST_PERIOD);
    chk({run_out, count_value_out[6:0]}, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16], v);
      chk(v, rows[i][7:0]);
    end
    chk(cmp, 8'h3c);
    wr(`PTL_ADDR_PERIOD, 8'h05);
    wr(`PTL_ADDR_COUNT, 8'h00);
    wr(`PTL_ADDR_CTRL, 8'h80);
    poll(0);
    tick(1);
    chk(count_value_out, 8'h00);
    tick(1);
    chk(count_value_out, 8'h01);
    wr(`PTL_ADDR_CTRL, 8'h00);
    tick(2);
    v = count_value_out;
    tick(6);
    chk(count_value_out, v);
    wr(`PTL_ADDR_PERIOD, 8'hff);
    for (m = 1; m < 8; m = m + 1) begin
      setx(m == 2 || m == 4 || m == 6);
      tick(4);
      wr(`PTL_ADDR_CTRL, 8'h80 | m[7:0]);
      wr(`PTL_ADDR_COUNT, 8'h00);
      tick(8);
      if (m < 3) begin
        chk(count_value_out, 8'h00);
        setx(m == 1);
        tick(8);
        chk(count_value_out != 8'h00, 8'h01);
      end else if (m < 6) begin
        v = starts;
        setx(m != 4);
        tick(8);
        chk(count_value_out > 8'h0c, m != 3);
        setx(m == 4);
        tick(8);
        chk(count_value_out < 8'h0c, 8'h01);
        chk(starts - v, (m == 3) ? 8'h02 : 8'h01);
      end else begin
        setx(m == 7);
        tick(10);
        chk(count_value_out, 8'h00);
        rd(`PTL_ADDR_STATUS, v);
        chk(v, (m == 7) ? 8'h0e : 8'h06);
        setx(m == 6);
        tick(8);
        chk(count_value_out != 8'h00, 8'h01);
        wr(`PTL_ADDR_CTRL, m[7:0]);
        wr(`PTL_ADDR_COUNT, 8'h40);
        setx(m == 7);
        tick(8);
        chk(count_value_out, 8'h40);
      end
    end
    wr(`PTL_ADDR_PERIOD, 8'h0a);
    wr(`PTL_ADDR_COUNT, 8'h00);
    wr(`PTL_ADDR_CTRL, 8'h88);
    tick(3);
    wr(`PTL_ADDR_CTRL, 8'h08);
    tick(2);
    v = count_value_out;
    tick(6);
    chk(count_value_out, v);
    wr(`PTL_ADDR_CTRL, 8'h88);
    poll(1);
    chk(count_value_out, 8'h00);
    tick(6);
    chk({run_out, count_value_out[6:0]}, 8'h00);
    wr(`PTL_ADDR_PERIOD, 8'h20);
    for (m = 9; m < 12; m = m + 1) begin
      setx(m == 10);
      tick(4);
      wr(`PTL_ADDR_COUNT, 8'h00);
      wr(`PTL_ADDR_CTRL, 8'h80 | m[7:0]);
      tick(6);
      chk(count_value_out, 8'h00);
      kick(m == 10);
      wr(`PTL_ADDR_CTRL, m[7:0]);
      wr(`PTL_ADDR_CTRL, 8'h80 | m[7:0]);
      tick(4);
      v = count_value_out;
      tick(6);
      chk(count_value_out, v);
      kick(m == 10);
      poll(1);
      chk({run_out, count_value_out[6:0]}, 8'h00);
    end
    wr(`PTL_ADDR_PERIOD, 8'h03);
    wr(`PTL_ADDR_SCALE, 8'h10);
    wr(`PTL_ADDR_CTRL, 8'h80);
    tick(4);
    pm0 = n_pm;
    pe0 = n_pe;
    tick(40);
    i = (n_pm - pm0) - 2 * (n_pe - pe0);
    chk(i >= -1 && i <= 1 && n_pe > pe0, 8'h01);
    wr(`PTL_ADDR_SCALE, 8'h01);
    wr(`PTL_ADDR_PERIOD, 8'hff);
    wr(`PTL_ADDR_COUNT, 8'h00);
    tick(20);
    chk(count_value_out >= 8'h08 && count_value_out <= 8'h0c, 8'h01);
    wr(`PTL_ADDR_SCALE, 8'h00);
    wr(`PTL_ADDR_CTRL, 8'h40);
    wr(`PTL_ADDR_COUNT, 8'h00);
    wr(`PTL_ADDR_CTRL, 8'hc0);
    tick(4);
    chk(count_value_out, 8'h00);
    tick(20);
    chk(count_value_out, 8'h0a);
    rst(3);
    tick(1);
    chk({run_out, count_value_out[6:0]}, 8'h00);
    rd(`PTL_ADDR_PERIOD, v);
    chk(v, `PTL_RST_PERIOD);
    conclude;
  end
endmodule
